// *** hdl/spio_pkg.sv ***
// constants and state types for the shared-pin i/o port slice
// assumes a 32-bit apb slave with byte addresses on an 8-bit paddr
package spio_pkg;

  localparam int          PORT_W      = 16;          // pins in the port
  localparam int          CN_W        = 21;          // change notice inputs
  localparam int          CN_LO_W     = 16;          // enable/pull-up low word width
  localparam int          CN_HI_W     = 5;           // enable/pull-up high word width
  localparam int          RP_SEL_W    = 5;           // remap output select code width
  localparam int          RP_FUNCS    = 32;          // peripheral output functions
  localparam int          ADDR_W      = 8;           // apb address width

  localparam logic [15:0] IMPL_MASK   = 16'h7FFF;    // bits present on this part
  localparam logic [15:0] ANALOG_MASK = 16'h003F;    // pins with an analog function
  localparam logic [15:0] DIR_RST     = IMPL_MASK;   // all present pins inputs
  localparam logic [15:0] LAT_RST     = 16'h0000;
  localparam logic [15:0] OD_RST      = 16'h0000;
  localparam logic [15:0] AN_RST      = 16'h0000;    // analog mode after reset
  localparam logic [20:0] CN_RST      = 21'h000000;
  localparam logic [4:0]  RP_SEL_PORT = 5'h00;       // code that keeps port logic

  localparam logic [7:0]  ADDR_DIR    = 8'h00;
  localparam logic [7:0]  ADDR_LAT    = 8'h04;
  localparam logic [7:0]  ADDR_LEVEL  = 8'h08;
  localparam logic [7:0]  ADDR_OD     = 8'h0C;
  localparam logic [7:0]  ADDR_AN     = 8'h10;
  localparam logic [7:0]  ADDR_CNEN_L = 8'h14;
  localparam logic [7:0]  ADDR_CNEN_H = 8'h18;
  localparam logic [7:0]  ADDR_CNPU_L = 8'h1C;
  localparam logic [7:0]  ADDR_CNPU_H = 8'h20;
  localparam logic [7:0]  ADDR_CNSTAT = 8'h24;
  localparam int          FLAG_BIT    = 0;           // flag position in status word

  // main register file and synchronisers
  typedef struct packed {
    logic [15:0] dir;
    logic [15:0] lat;
    logic [15:0] od;
    logic [15:0] ancfg;
    logic [20:0] cnen;
    logic [20:0] cnpu;
    logic [15:0] pin_s1;
    logic [15:0] pin_s2;
    logic [4:0]  ext_s1;
    logic [4:0]  ext_s2;
    logic [31:0] prdata;
    logic        pslverr;
  } spio_regs_t;

  // change detector state
  typedef struct packed {
    logic [20:0] prev;
    logic        primed;
    logic        flag;
  } spio_cn_t;

endpackage

// *** hdl/spio_cn_detect.sv ***
// change notice detector: compares enabled inputs with their last sample
// assumes cn_level is already synchronised to mclk; cn_raw comes straight off pins
`timescale 1ns/1ps
module spio_cn_detect
  import spio_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  input  wire logic [CN_W-1:0]   cn_level,
  input  wire logic [CN_W-1:0]   cn_raw,
  input  wire logic [CN_W-1:0]   cn_enable,
  input  wire logic              flag_clear,
  output logic                   cn_flag,
  output logic                   cn_wake
);

  spio_cn_t    st;        // registered state
  spio_cn_t    next_st;   // next state
  logic        changed;   // any enabled input moved

  // clocked compare; needs a first sample before it can flag
  assign changed = st.primed && ((cn_level ^ st.prev) & cn_enable) != CN_RST; // [RL22]

  // wake path is purely combinational so it works with mclk stopped
  assign cn_wake = ((cn_raw ^ st.prev) & cn_enable) != CN_RST; // [RL15]
  assign cn_flag = st.flag;

  // next state: set beats clear in the same cycle
  always_comb begin
    next_st        = st;
    next_st.prev   = cn_level;
    next_st.primed = 1'b1;
    if (changed) begin
      next_st.flag = 1'b1; // [RL22]
    end else if (flag_clear) begin
      next_st.flag = 1'b0;
    end
  end

  // state register
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st <= '{prev: CN_RST, primed: 1'b0, flag: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  a_cn_flag_set: assert property (changed |=> st.flag) // [RL22]
    else $error("change seen but flag not set");
  c_cn_change: cover property (changed ##1 flag_clear ##1 !st.flag);

endmodule // spio_cn_detect

// *** hdl/spio_port.sv ***
// shared-pin i/o port slice: direction, latch, pin levels, open drain,
// analog select, peripheral hand-over and change notification
// assumes an apb master on mclk and pins that are asynchronous to it
//
// Operation
// RL1: peripheral output overrides port through muxes
// RL2: port's own output never reaches peripheral
// RL3: driving peripheral disables port driver, pin readable
// RL4: idle enabled peripheral lets port drive
// RL5: direction bit one means input
// RL6: every pin is input after reset
// RL7: latch reads back stored latch, writes latch
// RL8: level read returns pins, write goes latch
// RL9: absent bits read zero
// RL10: open-drain bit makes pin open drain
// RL11: analog config resets zero, pins analog
// RL12: software sets input for analog pins
// RL13: analog pins read zero in level register
// RL14: software waits a cycle before reading pins
// RL15: change detection works with clocks stopped
// RL16: up to 21 change notice inputs
// RL17: either enable word enables change interrupt
// RL18: either pull-up word enables weak pull-up
// RL19: software keeps pull-ups off on outputs
// RL20: remap on fixed subset of pins
// RL21: select code zero keeps default port logic
// RL22: compare with last sample, latch shared flag
//
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module spio_port
  import spio_pkg::*;
(
  input  wire logic                         mclk,
  input  wire logic                         sys_rst,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [ADDR_W-1:0]            paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic [PORT_W-1:0]            pin_in,
  output logic      [PORT_W-1:0]            pin_out,
  output logic      [PORT_W-1:0]            pin_oe,
  input  wire logic [CN_HI_W-1:0]           cn_ext_in,
  output logic      [CN_W-1:0]              pullup_en,
  output logic      [PORT_W-1:0]            analog_mode,
  input  wire logic [PORT_W*RP_SEL_W-1:0]   rp_out_sel,
  input  wire logic [RP_FUNCS-1:0]          func_out,
  input  wire logic [RP_FUNCS-1:0]          func_drive,
  output logic      [PORT_W-1:0]            periph_pin_in,
  output logic                              cn_irq,
  output logic                              cn_wake
);

  spio_regs_t          st;            // registered state
  spio_regs_t          next_st;       // next state
  logic [PORT_W-1:0]   port_en;       // port wants to drive
  logic [PORT_W-1:0]   periph_drv;    // peripheral owns the pin
  logic [PORT_W-1:0]   periph_dat;    // peripheral data per pin
  logic [PORT_W-1:0]   own_en;        // muxed drive enable
  logic [PORT_W-1:0]   own_dat;       // muxed drive data
  logic [PORT_W-1:0]   level_view;    // pin levels as software sees them
  logic [CN_W-1:0]     cn_level;      // synchronised change notice inputs
  logic [CN_W-1:0]     cn_raw;        // raw inputs for the sleep wake path
  logic                cn_flag;       // shared change flag
  logic                setup_ph;      // apb setup cycle
  logic                wr_acc;        // apb write in access phase
  logic                flag_clear;    // status write-one-to-clear

  // address decode shared by read and write paths
  function automatic logic addr_known(input logic [ADDR_W-1:0] a);
    unique case (a)
      ADDR_DIR, ADDR_LAT, ADDR_LEVEL, ADDR_OD, ADDR_AN, ADDR_CNEN_L,
      ADDR_CNEN_H, ADDR_CNPU_L, ADDR_CNPU_H, ADDR_CNSTAT: addr_known = 1'b1;
      default: addr_known = 1'b0;
    endcase
  endfunction

  // select code of one remappable pin
  function automatic logic [RP_SEL_W-1:0] rp_sel(input int idx,
                                                 input logic [PORT_W*RP_SEL_W-1:0] bus);
    rp_sel = bus[idx*RP_SEL_W +: RP_SEL_W];
  endfunction

  // zero wait states; read data was captured during setup
  assign pready     = 1'b1;
  assign prdata     = st.prdata;
  assign pslverr    = st.pslverr;
  assign setup_ph   = psel && !penable;
  assign wr_acc     = psel && penable && pwrite && addr_known(paddr);
  assign flag_clear = wr_acc && (paddr == ADDR_CNSTAT) && pwdata[FLAG_BIT];

  // direction bit low means the port drives; absent bits never drive
  assign port_en = ~st.dir & IMPL_MASK; // [RL5] [RL9]

  // per-pin ownership mux; every pin here is remappable
  generate
    for (genvar i = 0; i < PORT_W; i++) begin : g_pin
      logic [RP_SEL_W-1:0] sel; // output function of this pin
      assign sel = rp_sel(i, rp_out_sel); // [RL20]
      // code zero ties the pin to its port logic
      assign periph_drv[i] = (sel != RP_SEL_PORT) && func_drive[sel]; // [RL21] [RL3]
      assign periph_dat[i] = (sel != RP_SEL_PORT) && func_out[sel];
      // peripheral wins while it drives, else port keeps the pin
      assign own_en[i]  = periph_drv[i] ? 1'b1 : port_en[i]; // [RL1] [RL4]
      assign own_dat[i] = periph_drv[i] ? periph_dat[i] : st.lat[i]; // [RL1]
    end
  endgenerate

  // open drain only pulls low; a high is released to the outside pull-up
  assign pin_oe  = own_en & ~(st.od & own_dat); // [RL10]
  assign pin_out = own_dat & ~st.od; // [RL10]

  // peripheral never sees the port's own drive on its pin
  assign periph_pin_in = st.pin_s2 & ~(port_en & ~periph_drv); // [RL2]

  // analog pins have their digital read masked off
  assign analog_mode = ~st.ancfg & ANALOG_MASK; // [RL11]
  assign level_view  = st.pin_s2 & ~analog_mode & IMPL_MASK; // [RL13] [RL3] [RL9]

  // change notice inputs: port pins then the extra pins
  assign cn_level  = {st.ext_s2, st.pin_s2}; // [RL16]
  assign cn_raw    = {cn_ext_in, pin_in};
  assign pullup_en = st.cnpu; // [RL18]
  assign cn_irq    = cn_flag;

  // change detector; wake path runs without the clock
  spio_cn_detect u_cn (
    .mclk       (mclk),
    .sys_rst    (sys_rst),
    .cn_level   (cn_level),
    .cn_raw     (cn_raw),
    .cn_enable  (st.cnen), // [RL17]
    .flag_clear (flag_clear),
    .cn_flag    (cn_flag),
    .cn_wake    (cn_wake)
  );

  // next state: synchronisers, register writes and read capture
  always_comb begin
    next_st        = st;
    // two-stage sync; stage one feeds stage two only
    next_st.pin_s1 = pin_in;
    next_st.pin_s2 = st.pin_s1;
    next_st.ext_s1 = cn_ext_in;
    next_st.ext_s2 = st.ext_s1;
    // writes land at the access edge
    if (wr_acc) begin
      unique case (paddr)
        ADDR_DIR:    next_st.dir   = pwdata[15:0] & IMPL_MASK; // [RL5] [RL9]
        ADDR_LAT:    next_st.lat   = pwdata[15:0] & IMPL_MASK; // [RL7]
        ADDR_LEVEL:  next_st.lat   = pwdata[15:0] & IMPL_MASK; // [RL8]
        ADDR_OD:     next_st.od    = pwdata[15:0] & IMPL_MASK; // [RL10]
        ADDR_AN:     next_st.ancfg = pwdata[15:0] & ANALOG_MASK;
        ADDR_CNEN_L: next_st.cnen[CN_LO_W-1:0] = pwdata[CN_LO_W-1:0]; // [RL17]
        ADDR_CNEN_H: next_st.cnen[CN_W-1:CN_LO_W] = pwdata[CN_HI_W-1:0]; // [RL17]
        ADDR_CNPU_L: next_st.cnpu[CN_LO_W-1:0] = pwdata[CN_LO_W-1:0]; // [RL18]
        ADDR_CNPU_H: next_st.cnpu[CN_W-1:CN_LO_W] = pwdata[CN_HI_W-1:0]; // [RL18]
        default:     next_st.cnpu  = st.cnpu; // status is handled by the detector
      endcase
    end
    // read data captured in setup, shown in access
    if (setup_ph) begin
      next_st.pslverr = !addr_known(paddr);
      next_st.prdata  = 32'h00000000;
      if (!pwrite) begin
        unique case (paddr)
          ADDR_DIR:    next_st.prdata[15:0] = st.dir;
          ADDR_LAT:    next_st.prdata[15:0] = st.lat; // [RL7]
          ADDR_LEVEL:  next_st.prdata[15:0] = level_view; // [RL8] [RL13]
          ADDR_OD:     next_st.prdata[15:0] = st.od;
          ADDR_AN:     next_st.prdata[15:0] = st.ancfg;
          ADDR_CNEN_L: next_st.prdata[CN_LO_W-1:0] = st.cnen[CN_LO_W-1:0];
          ADDR_CNEN_H: next_st.prdata[CN_HI_W-1:0] = st.cnen[CN_W-1:CN_LO_W];
          ADDR_CNPU_L: next_st.prdata[CN_LO_W-1:0] = st.cnpu[CN_LO_W-1:0];
          ADDR_CNPU_H: next_st.prdata[CN_HI_W-1:0] = st.cnpu[CN_W-1:CN_LO_W];
          ADDR_CNSTAT: next_st.prdata[FLAG_BIT]    = cn_flag;
          default:     next_st.prdata = 32'h00000000; // unmapped reads zero
        endcase
      end
    end
  end

  // state register; all present pins come out of reset as inputs
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st <= '{dir: DIR_RST, lat: LAT_RST, od: OD_RST, ancfg: AN_RST, // [RL6] [RL11]
              cnen: CN_RST, cnpu: CN_RST, pin_s1: 16'h0000, pin_s2: 16'h0000,
              ext_s1: 5'h00, ext_s2: 5'h00, prdata: 32'h00000000, pslverr: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // checks beside the logic they guard
  a_periph_owns_data: assert property (((own_dat ^ periph_dat) & periph_drv) == 16'h0000) // [RL1]
    else $error("peripheral lost ownership of a driven pin");
  a_port_idle_fallback: assert property (((own_en ^ port_en) & ~periph_drv) == 16'h0000) // [RL4]
    else $error("port not driving where peripheral is idle");
  a_no_loop_through: assert property ((periph_pin_in & port_en & ~periph_drv) == 16'h0000) // [RL2]
    else $error("port output looped into peripheral input");
  // only a driving peripheral may hold a pin enabled right out of reset
  a_reset_all_inputs: assert property ( // [RL6]
    $fell(sys_rst) |-> st.dir == DIR_RST && (pin_oe & ~periph_drv) == 16'h0000)
    else $error("pin driven by port after reset");
  a_latch_write_read: assert property ( // [RL7]
    wr_acc && paddr == ADDR_LAT |=> st.lat == ($past(pwdata[15:0]) & IMPL_MASK))
    else $error("latch write did not land");
  a_latch_readback: assert property ( // [RL7]
    setup_ph && !pwrite && paddr == ADDR_LAT |=> prdata[15:0] == $past(st.lat))
    else $error("latch readback differs from latch");
  a_level_write_latch: assert property ( // [RL8]
    wr_acc && paddr == ADDR_LEVEL |=> st.lat == ($past(pwdata[15:0]) & IMPL_MASK))
    else $error("pin level write missed the latch");
  a_analog_reads_zero: assert property ( // [RL13]
    setup_ph && !pwrite && paddr == ADDR_LEVEL |=> (prdata[15:0] & $past(analog_mode)) == 16'h0000)
    else $error("analog pin read as one");
  a_open_drain_high: assert property ((pin_oe & st.od & own_dat) == 16'h0000) // [RL10]
    else $error("open drain pin drove high");
  a_absent_bits_zero: assert property ( // [RL9]
    ((st.dir | st.lat | st.od | level_view) & ~IMPL_MASK) == 16'h0000)
    else $error("absent bit reads nonzero");
  a_port_drive_dir: assert property ( // [RL5]
    (own_en & ~periph_drv) == (~st.dir & IMPL_MASK & ~periph_drv))
    else $error("direction bit does not steer port driver");

  c_periph_takes_pin: cover property (port_en != 16'h0000 ##1 (periph_drv & port_en) != 16'h0000);
  c_level_write_read: cover property (wr_acc && paddr == ADDR_LEVEL ##[1:4] setup_ph && paddr == ADDR_LEVEL);
  c_open_drain_low: cover property ((pin_oe & st.od) != 16'h0000);
  c_unmapped_access: cover property (setup_ph ##1 pslverr);

endmodule // spio_port

// *** tb/spio_pins_model.sv ***
// pad model: resolves each pin from port drive, outside drivers and pull-ups
// assumes pin_out/pin_oe come straight from the port; mclk paces the float pattern
`timescale 1ns/1ps
module spio_pins_model
  import spio_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic [PORT_W-1:0] pin_out,
  input  wire logic [PORT_W-1:0] pin_oe,
  input  wire logic [PORT_W-1:0] pull_en,
  input  wire logic [PORT_W-1:0] ext_en,
  input  wire logic [PORT_W-1:0] ext_val,
  output logic      [PORT_W-1:0] pin_in
);
  logic [PORT_W-1:0] drift = '0; // undriven pads wander, never keep a value

  // float pattern flips every cycle so a stale level is never mistaken
  always @(posedge mclk) begin
    drift <= ~drift;
  end

  // port drive wins, then the outside driver, then the weak pull-up
  always_comb begin
    for (int i = 0; i < PORT_W; i++) begin
      if (pin_oe[i]) begin
        pin_in[i] = pin_out[i];
      end else if (ext_en[i]) begin
        pin_in[i] = ext_val[i];
      end else begin
        pin_in[i] = pull_en[i] ? 1'b1 : drift[i];
      end
    end
  end
endmodule // spio_pins_model

// *** tb/spio_port_tb_top.sv ***
// self-checking bench for the port slice, registers reached over apb
// assumes the pad model closes the loop from pin_out/pin_oe back to pin_in
`timescale 1ns/1ps
module spio_port_tb_top
  import spio_pkg::*;
;
  logic                       mclk = 1'b0, sys_rst = 1'b1;
  logic                       psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]                 paddr = 8'h00;
  logic [31:0]                pwdata = 32'h0, prdata, rd;
  logic                       pready, pslverr, err, cn_irq, cn_wake;
  logic [PORT_W-1:0]          pin_in, pin_out, pin_oe, analog_mode, periph_pin_in;
  logic [PORT_W-1:0]          ext_en = 16'hFFFF, ext_val = 16'hDA00;
  logic [CN_HI_W-1:0]         cn_ext_in = 5'h00;
  logic [CN_W-1:0]            pullup_en;
  logic [PORT_W*RP_SEL_W-1:0] rp_out_sel = '0;
  logic [RP_FUNCS-1:0]        func_out = '0, func_drive = '1;
  int                         miscompares = 0, checks_done = 0;
  // register table: address, value written, value read back
  logic [7:0]  ra [8] = '{ADDR_DIR, ADDR_LAT, ADDR_OD, ADDR_AN,
                          ADDR_CNEN_L, ADDR_CNEN_H, ADDR_CNPU_L, ADDR_CNPU_H};
  logic [31:0] wv [8] = '{32'hFFFFFFFF, 32'hFFFFFFFF, 32'h00000015, 32'h00000015,
                          32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF};
  logic [31:0] rv [8] = '{32'h00007FFF, 32'h00007FFF, 32'h00000015, 32'h00000015,
                          32'h0000FFFF, 32'h0000001F, 32'h0000FFFF, 32'h0000001F};

  always #4 mclk = ~mclk; // 125 MHz

  spio_port DUT (
    .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .cn_ext_in(cn_ext_in), .pullup_en(pullup_en), .analog_mode(analog_mode),
    .rp_out_sel(rp_out_sel), .func_out(func_out), .func_drive(func_drive),
    .periph_pin_in(periph_pin_in), .cn_irq(cn_irq), .cn_wake(cn_wake));

  spio_pins_model PADS (
    .mclk(mclk), .pin_out(pin_out), .pin_oe(pin_oe), .pull_en(pullup_en[PORT_W-1:0]),
    .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

  // verdict and end of run, also reached by any exhausted wait
  task automatic tally_and_finish();
    if (miscompares == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // value compare; four-state so unknowns never match
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask

  // one apb transfer, entered just after a rising edge; request held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      miscompares++;
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rd);
  endtask

  // bounded wait for the change flag; give up counts as a miss
  task automatic wait_irq();
    int n;
    for (n = 0; n < 10 && cn_irq !== 1'b1; n++) begin
      @(posedge mclk);
    end
    chk("cn_irq", 32'h1, {31'h0, cn_irq});
    if (cn_irq !== 1'b1) tally_and_finish();
  endtask

  initial begin
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    #1;
    chk("pin_oe", 32'h0, {16'h0, pin_oe});
    chk("analog_mode", 32'h3F, {16'h0, analog_mode});
    @(posedge mclk);
    for (int i = 0; i < 8; i++) begin
      rdchk("reset", ra[i], (i == 0) ? 32'h7FFF : 32'h0);
    end
    for (int i = 0; i < 8; i++) begin
      wr(ra[i], wv[i]);
      rdchk("readback", ra[i], rv[i]);
    end
    #1;
    chk("pullup_en", 32'h1FFFFF, {11'h0, pullup_en});
    chk("analog_mode", 32'h2A, {16'h0, analog_mode});
    @(posedge mclk);
    // pull-ups off before any pin becomes an output
    for (int i = 1; i < 8; i++) wr(ra[i], 32'h0);
    wr(ADDR_AN, 32'h3F);
    wr(ADDR_CNSTAT, 32'h1);
    // unmapped place: refused, reads zero
    wr(8'h40, 32'hFFFF);
    chk("wr_slverr", 32'h1, {31'h0, err});
    rdchk("unmapped", 8'h40, 32'h0);
    chk("rd_slverr", 32'h1, {31'h0, err});
    // low byte outputs, level write lands in the latch
    wr(ADDR_DIR, 32'hFF00);
    wr(ADDR_LEVEL, 32'h00A5);
    rdchk("latch", ADDR_LAT, 32'h00A5);
    #1;
    chk("pin_oe", 32'h00FF, {16'h0, pin_oe});
    chk("pin_out", 32'hA5, {24'h0, pin_out[7:0]});
    chk("periph_in", 32'h5A00, {17'h0, periph_pin_in[14:0]});
    @(posedge mclk);
    rdchk("level", ADDR_LEVEL, 32'h5AA5);
    wr(ADDR_OD, 32'h0003);
    #1;
    chk("od_oe", 32'h2, {30'h0, pin_oe[1:0]});
    chk("od_out", 32'h0, {30'h0, pin_out[1:0]});
    @(posedge mclk);
    wr(ADDR_OD, 32'h0);
    // pin 2 handed to function 3, which drives low over a latch of 1
    rp_out_sel <= (PORT_W*RP_SEL_W)'(5'h03) << 10;
    func_out <= '0;
    @(posedge mclk);
    #1;
    chk("periph_oe", 32'h1, {31'h0, pin_oe[2]});
    chk("periph_out", 32'h0, {31'h0, pin_out[2]});
    @(posedge mclk);
    rdchk("level_periph", ADDR_LEVEL, 32'h5AA1);
    func_drive <= '0;
    @(posedge mclk);
    #1;
    chk("idle_oe", 32'h1, {31'h0, pin_oe[2]});
    chk("idle_out", 32'h1, {31'h0, pin_out[2]});
    @(posedge mclk);
    rp_out_sel <= '0;
    ext_val <= 16'hDA3F;
    wr(ADDR_DIR, 32'h7FFF);
    #1;
    chk("pin_oe", 32'h0, {16'h0, pin_oe});
    @(posedge mclk);
    wr(ADDR_AN, 32'h0);
    rdchk("level_analog", ADDR_LEVEL, 32'h5A00);
    wr(ADDR_AN, 32'h3F);
    rdchk("level_digital", ADDR_LEVEL, 32'h5A3F);
    // change notice on pin 9 and extra input 1 only
    wr(ADDR_CNEN_L, 32'h0200);
    wr(ADDR_CNEN_H, 32'h0002);
    wr(ADDR_CNSTAT, 32'h1);
    rdchk("cn_clear", ADDR_CNSTAT, 32'h0);
    ext_val <= 16'hDB3F;
    repeat (6) @(posedge mclk);
    #1;
    chk("cn_off_pin", 32'h0, {31'h0, cn_irq});
    @(posedge mclk);
    ext_val <= 16'hD93F;
    #1;
    chk("cn_wake", 32'h1, {31'h0, cn_wake});
    @(posedge mclk);
    wait_irq();
    rdchk("cn_stat", ADDR_CNSTAT, 32'h1);
    wr(ADDR_CNSTAT, 32'h1);
    rdchk("cn_clear", ADDR_CNSTAT, 32'h0);
    cn_ext_in <= 5'h01;
    repeat (6) @(posedge mclk);
    #1;
    chk("cn_off_ext", 32'h0, {31'h0, cn_irq});
    @(posedge mclk);
    cn_ext_in <= 5'h03;
    wait_irq();
    tally_and_finish();
  end
endmodule // spio_port_tb_top
